// ---- pecw_ctrl_decode.sv ----
/*
 * decodes the encoder, block select, manual input mode and positioning option words.
 * assumes: the telegram receiver presents each word with a one-cycle load strobe on clk,
 * and the position/actual value buses are in the same clock domain.
 */
`timescale 1ns/10ps
`include "pecw_map.svh"
module pecw_ctrl_decode (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // telegram words with load strobes
   input  wire logic        ecw_load,
   input  wire logic [15:0] encoder_control_word,
   input  wire logic        bsw_load,
   input  wire logic [15:0] block_select_word,
   input  wire logic        mim_load,
   input  wire logic [15:0] manual_input_mode_word,
   input  wire logic        pow_load,
   input  wire logic [15:0] positioning_options_word,
   // position path
   input  wire logic [31:0] actual_position,
   input  wire logic [31:0] commanded_setpoint,
   output logic      [31:0] position_setpoint,
   // encoder function outputs
   output logic      [3:0]  ref_mark_sel,
   output logic      [1:0]  probe_sel,
   output logic             flying_mode,
   output logic      [3:0]  fn_state,
   output logic             fn_start,
   output logic             fn_read,
   output logic             fn_abort,
   output logic             abs_value_request,
   output logic             park_request,
   output logic             fault_ack,
   // traversing and manual data input
   output logic      [5:0]  traversing_block,
   output logic             manual_data_input_active,
   output logic             manual_input_absolute,
   output logic      [1:0]  manual_input_direction,
   // positioning options
   output logic             tracking_mode,
   output logic             set_reference_point,
   output logic             reference_cam_active,
   output logic             jog_incremental
);
   // latched copies of the four words, reserved bits already masked
   logic [15:0] ecw_reg;
   logic [15:0] bsw_reg;
   logic [15:0] mim_reg;
   logic [15:0] pow_reg;
   // selectors held by the sequencer, cleared by abort
   logic [3:0]  fn_active;
   // previous acknowledge level for the edge detect
   logic        ack_prev_reg;
   // named fields of the latched words
   logic        ecw_flying;
   logic        ecw_abs_req;
   logic        ecw_park_req;
   logic        ecw_ack;
   logic [5:0]  bsw_block;
   logic        bsw_manual_on;
   logic        mim_abs;
   logic [1:0]  dir_field;
   logic        pow_track;
   logic        pow_ref;
   logic        pow_cam;
   logic        pow_jog;
   logic [3:0]  ref_mark_next;
   logic [1:0]  probe_next;

   pecw_word_latch #(
      .USED_MASK (`PECW_ECW_USED)
   ) u_ecw (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (ecw_load),
      .word_in  (encoder_control_word),
      .word_reg (ecw_reg),
      .changed  ()
   );

   pecw_word_latch #(
      .USED_MASK (`PECW_BSW_USED)
   ) u_bsw (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (bsw_load),
      .word_in  (block_select_word),
      .word_reg (bsw_reg),
      .changed  ()
   );

   pecw_word_latch #(
      .USED_MASK (`PECW_MIM_USED)
   ) u_mim (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (mim_load),
      .word_in  (manual_input_mode_word),
      .word_reg (mim_reg),
      .changed  ()
   );

   pecw_word_latch #(
      .USED_MASK (`PECW_POW_USED)
   ) u_pow (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (pow_load),
      .word_in  (positioning_options_word),
      .word_reg (pow_reg),
      .changed  ()
   );

   // command decoded straight from the incoming word so a strobe acts the same cycle it lands
   pecw_fn_seq u_seq (
      .clk         (clk),
      .rst_n       (rst_n),
      .load        (ecw_load),
      .cmd         (encoder_control_word[`PECW_ECW_CMD_LSB +: `PECW_ECW_CMD_W]),
      .sel         (encoder_control_word[`PECW_ECW_SEL_LSB +: `PECW_ECW_SEL_W]),
      .fn_state    (fn_state),
      .fn_active   (fn_active),
      .start_pulse (fn_start),
      .read_pulse  (fn_read),
      .abort_pulse (fn_abort)
   );

   assign ecw_flying    = ecw_reg[`PECW_ECW_MODE_BIT];
   assign ecw_abs_req   = ecw_reg[`PECW_ECW_ABS_BIT];
   assign ecw_park_req  = ecw_reg[`PECW_ECW_PARK_BIT];
   assign ecw_ack       = ecw_reg[`PECW_ECW_ACK_BIT];
   assign bsw_block     = bsw_reg[`PECW_BSW_BLK_W-1:0];
   assign bsw_manual_on = bsw_reg[`PECW_BSW_MANUAL_BIT];
   assign mim_abs       = mim_reg[`PECW_MIM_ABS_BIT];
   assign dir_field     = mim_reg[`PECW_MIM_DIR_LSB +: 2];
   assign pow_track     = pow_reg[`PECW_POW_TRK_BIT];
   assign pow_ref       = pow_reg[`PECW_POW_REF_BIT];
   assign pow_cam       = pow_reg[`PECW_POW_CAM_BIT];
   assign pow_jog       = pow_reg[`PECW_POW_JOG_BIT];

   // a selector reaches its reference mark only while searching, never while measuring
   genvar gi;
   generate
      for (gi = 0; gi < `PECW_ECW_SEL_W; gi = gi + 1) begin : g_sel
         assign ref_mark_next[gi] = fn_active[gi] && !ecw_flying;
      end
   endgenerate

   // probe one answers selectors one and two, probe two selectors three and four
   assign probe_next[0] = ecw_flying && (fn_active[0] || fn_active[1]);
   assign probe_next[1] = ecw_flying && (fn_active[2] || fn_active[3]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flying_mode <= 1'b0;
      end else begin
         flying_mode <= ecw_flying;
      end
   end

   // selectors route by the mode latched with the same command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_mark_sel <= 4'h0;
      end else begin
         ref_mark_sel <= ref_mark_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         probe_sel <= 2'h0;
      end else begin
         probe_sel <= probe_next;
      end
   end

   // absolute value and parking requests follow their bits while they stay set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         abs_value_request <= 1'b0;
      end else begin
         abs_value_request <= ecw_abs_req;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         park_request <= 1'b0;
      end else begin
         park_request <= ecw_park_req;
      end
   end

   // acknowledge is edge driven: a held bit must not keep clearing new faults
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_prev_reg <= 1'b0;
      end else begin
         ack_prev_reg <= ecw_ack;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_ack <= 1'b0;
      end else begin
         fault_ack <= ecw_ack && !ack_prev_reg;
      end
   end

   // block number and manual input switch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         traversing_block <= 6'h00;
      end else begin
         traversing_block <= bsw_block;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_data_input_active <= 1'b0;
      end else begin
         manual_data_input_active <= bsw_manual_on;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_input_absolute <= 1'b0;
      end else begin
         manual_input_absolute <= mim_abs;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_input_direction <= pecw_pkg::PECW_DIR_SHORTEST;
      end else begin
         case (dir_field)
            `PECW_DIR_POS: manual_input_direction <= pecw_pkg::PECW_DIR_POSITIVE;
            `PECW_DIR_NEG: manual_input_direction <= pecw_pkg::PECW_DIR_NEGATIVE;
            default:       manual_input_direction <= pecw_pkg::PECW_DIR_SHORTEST;
         endcase
      end
   end

   // option bits are levels the motion core reads every cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tracking_mode <= 1'b0;
      end else begin
         tracking_mode <= pow_track;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         set_reference_point <= 1'b0;
      end else begin
         set_reference_point <= pow_ref;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reference_cam_active <= 1'b0;
      end else begin
         reference_cam_active <= pow_cam;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         jog_incremental <= 1'b0;
      end else begin
         jog_incremental <= pow_jog;
      end
   end

   // setpoint registered so it lags inputs by one cycle either way
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         position_setpoint <= 32'h0000_0000;
      end else if (pow_track) begin
         position_setpoint <= actual_position;
      end else begin
         position_setpoint <= commanded_setpoint;
      end
   end
endmodule

// ---- pecw_ctrl_properties.sv ----
/* port assertions for the control word decoder.
   assumes: bound to pecw_ctrl_decode, one clock domain. */
`timescale 1ns/10ps
module pecw_ctrl_properties (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // telegram side
   input wire logic        ecw_load,
   input wire logic [15:0] encoder_control_word,
   input wire logic        bsw_load,
   input wire logic [15:0] block_select_word,
   input wire logic        mim_load,
   input wire logic [15:0] manual_input_mode_word,
   input wire logic        pow_load,
   input wire logic [15:0] positioning_options_word,
   input wire logic [31:0] actual_position,
   // decoded side
   input wire logic [31:0] position_setpoint,
   input wire logic [3:0]  ref_mark_sel,
   input wire logic        flying_mode,
   input wire logic [3:0]  fn_state,
   input wire logic        fn_start,
   input wire logic        fn_abort,
   input wire logic        abs_value_request,
   input wire logic        park_request,
   input wire logic        fault_ack,
   input wire logic [5:0]  traversing_block,
   input wire logic        manual_data_input_active,
   input wire logic        manual_input_absolute,
   input wire logic [1:0]  manual_input_direction,
   input wire logic        tracking_mode,
   input wire logic        set_reference_point,
   input wire logic        reference_cam_active,
   input wire logic        jog_incremental
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [15:0] ew = encoder_control_word;
   wire logic [15:0] pw = positioning_options_word;
   wire logic [1:0]  dir_exp = (manual_input_mode_word[2:1] == 2'h3) ? 2'h0 : manual_input_mode_word[2:1];
   start_entry_a: assert property (ecw_load && ew[6:4] == 3'h1 && !ew[7] && fn_state != 4'h2 |->
      ##1 fn_start && fn_state == 4'h2 ##1 ref_mark_sel == $past(ew[3:0], 2)) else $error("activate not decoded");
   abort_entry_a: assert property (ecw_load && ew[6:4] == 3'h3 && fn_state == 4'h2 |=>
      fn_abort && fn_state == 4'h8 ##1 ref_mark_sel == 4'h0) else $error("abort not decoded");
   mode_flags_a: assert property (ecw_load |-> ##2 flying_mode == $past(ew[7], 2) &&
      abs_value_request == $past(ew[13], 2) && park_request == $past(ew[14], 2)) else $error("encoder flags wrong");
   ack_pulse_a: assert property (fault_ack |=> !fault_ack) else $error("fault ack longer than one cycle");
   block_sel_a: assert property (bsw_load |-> ##2 traversing_block == $past(block_select_word[5:0], 2) &&
      manual_data_input_active == $past(block_select_word[15], 2)) else $error("block select wrong");
   manual_mode_a: assert property (mim_load |-> ##2
      manual_input_absolute == $past(manual_input_mode_word[0], 2) &&
      manual_input_direction == $past(dir_exp, 2)) else $error("manual input mode wrong");
   option_flags_a: assert property (pow_load |-> ##2 {jog_incremental, reference_cam_active,
      set_reference_point, tracking_mode} == $past({pw[5], pw[2:0]}, 2)) else $error("option flags wrong");
   setpoint_track_a: assert property (tracking_mode |->
      position_setpoint == $past(actual_position)) else $error("setpoint not tracking");
   cover property (fn_start);
   cover property (fault_ack);
   cover property (tracking_mode && manual_data_input_active);
endmodule
bind pecw_ctrl_decode pecw_ctrl_properties u_props (
   .clk(clk), .rst_n(rst_n), .ecw_load(ecw_load), .encoder_control_word(encoder_control_word),
   .bsw_load(bsw_load), .block_select_word(block_select_word), .mim_load(mim_load),
   .manual_input_mode_word(manual_input_mode_word), .pow_load(pow_load),
   .positioning_options_word(positioning_options_word), .actual_position(actual_position),
   .position_setpoint(position_setpoint), .ref_mark_sel(ref_mark_sel), .flying_mode(flying_mode),
   .fn_state(fn_state), .fn_start(fn_start), .fn_abort(fn_abort), .abs_value_request(abs_value_request),
   .park_request(park_request), .fault_ack(fault_ack), .traversing_block(traversing_block),
   .manual_data_input_active(manual_data_input_active), .manual_input_absolute(manual_input_absolute),
   .manual_input_direction(manual_input_direction), .tracking_mode(tracking_mode),
   .set_reference_point(set_reference_point), .reference_cam_active(reference_cam_active),
   .jog_incremental(jog_incremental));

// ---- pecw_fn_seq.sv ----
/*
 * encoder function sequencer: tracks the command field of the encoder control word.
 * assumes: cmd and sel only meaningful when load is high; one clock domain.
 */
`timescale 1ns/10ps
`include "pecw_map.svh"
module pecw_fn_seq (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // decoded command
   input  wire logic       load,
   input  wire logic [2:0] cmd,
   input  wire logic [3:0] sel,
   // function state
   output logic      [3:0] fn_state,
   output logic      [3:0] fn_active,
   output logic            start_pulse,
   output logic            read_pulse,
   output logic            abort_pulse
);
   pecw_pkg::pecw_fn_state_e state_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= pecw_pkg::PECW_FN_IDLE;
         fn_active   <= 4'h0;
         start_pulse <= 1'b0;
         read_pulse  <= 1'b0;
         abort_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         read_pulse  <= 1'b0;
         abort_pulse <= 1'b0;
         if (load) begin
            case (cmd)
               `PECW_CMD_ACTIVATE: begin
                  // repeating the same command every cycle must not restart the function
                  if (state_reg != pecw_pkg::PECW_FN_ACTIVE || fn_active != sel) begin
                     start_pulse <= 1'b1;
                  end
                  state_reg <= pecw_pkg::PECW_FN_ACTIVE;
                  fn_active <= sel;
               end
               `PECW_CMD_READ: begin
                  if (state_reg != pecw_pkg::PECW_FN_READBACK) begin
                     read_pulse <= 1'b1;
                  end
                  state_reg <= pecw_pkg::PECW_FN_READBACK;
               end
               `PECW_CMD_ABORT: begin
                  if (state_reg != pecw_pkg::PECW_FN_ABORTED) begin
                     abort_pulse <= 1'b1;
                  end
                  state_reg <= pecw_pkg::PECW_FN_ABORTED;
                  fn_active <= 4'h0;
               end
               default: begin
                  state_reg <= pecw_pkg::PECW_FN_IDLE;
               end
            endcase
         end
      end
   end

   assign fn_state = state_reg;
endmodule

// ---- pecw_map.svh ----
/*
 * bit positions, field codes and reset values of the four cyclic control words.
 * assumes: included by bare name from the design modules.
 */
`ifndef PECW_MAP_SVH
`define PECW_MAP_SVH

`define PECW_WORD_W        16
`define PECW_WORD_RST      16'h0000
`define PECW_ECW_SEL_LSB   0
`define PECW_ECW_SEL_W     4
`define PECW_ECW_CMD_LSB   4
`define PECW_ECW_CMD_W     3
`define PECW_ECW_MODE_BIT  7
`define PECW_ECW_ABS_BIT   13
`define PECW_ECW_PARK_BIT  14
`define PECW_ECW_ACK_BIT   15
`define PECW_ECW_USED      16'hE0FF
`define PECW_CMD_NONE      3'h0
`define PECW_CMD_ACTIVATE  3'h1
`define PECW_CMD_READ      3'h2
`define PECW_CMD_ABORT     3'h3
`define PECW_BSW_BLK_W     6
`define PECW_BSW_MANUAL_BIT 15
`define PECW_BSW_USED      16'h803F
`define PECW_MIM_ABS_BIT   0
`define PECW_MIM_DIR_LSB   1
`define PECW_MIM_USED      16'h0007
`define PECW_DIR_POS       2'h1
`define PECW_DIR_NEG       2'h2
`define PECW_POW_TRK_BIT   0
`define PECW_POW_REF_BIT   1
`define PECW_POW_CAM_BIT   2
`define PECW_POW_JOG_BIT   5
`define PECW_POW_USED      16'h0027

`endif

// ---- pecw_master_model.sv ----
/* controller model: writes one control word with a one-cycle load strobe.
   assumes: called from the testbench main process, clk is the drive clock. */
`timescale 1ns/10ps
module pecw_master_model (
   // clock
   input  wire logic        clk,
   // telegram words with load strobes
   output wire logic        ecw_load,
   output wire logic        bsw_load,
   output wire logic        mim_load,
   output wire logic        pow_load,
   output wire logic [15:0] encoder_control_word,
   output wire logic [15:0] block_select_word,
   output wire logic [15:0] manual_input_mode_word,
   output wire logic [15:0] positioning_options_word
);
   logic [3:0]  ld = 4'h0;
   logic [15:0] wd [4] = '{default: 16'h5A5A};
   assign {pow_load, mim_load, bsw_load, ecw_load} = ld;
   assign encoder_control_word = wd[0];
   assign block_select_word = wd[1];
   assign manual_input_mode_word = wd[2];
   assign positioning_options_word = wd[3];
   task automatic send(input int which, input logic [15:0] w);
      @(posedge clk);
      #1;
      ld[which] = 1'b1;
      wd[which] = w;
      @(posedge clk);
      #1;
      ld[which] = 1'b0;
      // stale data is inverted so a decoder reading without the strobe shows up
      wd[which] = ~w;
   endtask
endmodule

// ---- pecw_pkg.sv ----
/*
 * types shared by the control word decoder.
 * assumes: pecw_map.svh is on the include path.
 */
package pecw_pkg;
   typedef enum logic [3:0] {
      PECW_FN_IDLE     = 4'b0001,
      PECW_FN_ACTIVE   = 4'b0010,
      PECW_FN_READBACK = 4'b0100,
      PECW_FN_ABORTED  = 4'b1000
   } pecw_fn_state_e;
   typedef enum logic [1:0] {
      PECW_DIR_SHORTEST = 2'h0,
      PECW_DIR_POSITIVE = 2'h1,
      PECW_DIR_NEGATIVE = 2'h2
   } pecw_dir_e;
endpackage

// ---- pecw_word_latch.sv ----
/*
 * latches one cyclic control word on the telegram strobe, reserved bits masked off.
 * assumes: strobe and word come from logic on clk.
 */
`timescale 1ns/10ps
`include "pecw_map.svh"
module pecw_word_latch #(
   parameter logic [15:0] USED_MASK = 16'hFFFF
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // telegram side
   input  wire logic        load,
   input  wire logic [15:0] word_in,
   // decoded side
   output logic      [15:0] word_reg,
   output logic             changed
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_reg <= `PECW_WORD_RST;
         changed  <= 1'b0;
      end else begin
         changed <= load && ((word_in & USED_MASK) != word_reg);
         if (load) begin
            word_reg <= word_in & USED_MASK;
         end
      end
   end
endmodule

// ---- positioning_encoder_control_words_tb.sv ----
/* self-checking bench for the control word decoder.
   assumes: pecw_map.svh on the include path, checker bound by its own file. */
`timescale 1ns/10ps
module positioning_encoder_control_words_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] encoder_control_word, block_select_word, manual_input_mode_word, positioning_options_word;
   logic [31:0] actual_position = 32'h0000_0000, commanded_setpoint = 32'h0000_0000, position_setpoint;
   logic [5:0]  traversing_block;
   logic [3:0]  ref_mark_sel, fn_state;
   logic [1:0]  probe_sel, manual_input_direction;
   logic        ecw_load, bsw_load, mim_load, pow_load, flying_mode, fn_start, fn_read, fn_abort, seen;
   logic        abs_value_request, park_request, fault_ack, manual_data_input_active, manual_input_absolute;
   logic        tracking_mode, set_reference_point, reference_cam_active, jog_incremental;
   int          fails = 0;
   int          check_count = 0;
   pecw_ctrl_decode u_dut (
      .clk(clk), .rst_n(rst_n), .ecw_load(ecw_load), .encoder_control_word(encoder_control_word),
      .bsw_load(bsw_load), .block_select_word(block_select_word), .mim_load(mim_load),
      .manual_input_mode_word(manual_input_mode_word), .pow_load(pow_load),
      .positioning_options_word(positioning_options_word), .actual_position(actual_position),
      .commanded_setpoint(commanded_setpoint), .position_setpoint(position_setpoint),
      .ref_mark_sel(ref_mark_sel), .probe_sel(probe_sel), .flying_mode(flying_mode), .fn_state(fn_state),
      .fn_start(fn_start), .fn_read(fn_read), .fn_abort(fn_abort), .abs_value_request(abs_value_request),
      .park_request(park_request), .fault_ack(fault_ack), .traversing_block(traversing_block),
      .manual_data_input_active(manual_data_input_active), .manual_input_absolute(manual_input_absolute),
      .manual_input_direction(manual_input_direction), .tracking_mode(tracking_mode),
      .set_reference_point(set_reference_point), .reference_cam_active(reference_cam_active),
      .jog_incremental(jog_incremental));
   pecw_master_model u_master (
      .clk(clk), .ecw_load(ecw_load), .bsw_load(bsw_load), .mim_load(mim_load), .pow_load(pow_load),
      .encoder_control_word(encoder_control_word), .block_select_word(block_select_word),
      .manual_input_mode_word(manual_input_mode_word), .positioning_options_word(positioning_options_word));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic test_encoder;
      chk(fn_state, 4'h1);
      u_master.send(0, 16'h0013);
      chk({fn_start, fn_state}, 5'h12);
      step;
      chk({flying_mode, ref_mark_sel}, 5'h03);
      // same command again must not restart, new selectors must
      u_master.send(0, 16'h0013);
      chk({fn_start, fn_state}, 5'h02);
      u_master.send(0, 16'h0015);
      chk({fn_start, fn_state}, 5'h12);
      u_master.send(0, 16'h0033);
      chk({fn_abort, fn_state}, 5'h18);
      step;
      chk(ref_mark_sel, 4'h0);
      // reserved bits 9 to 12 set on purpose
      u_master.send(0, 16'h1E91);
      step;
      chk({flying_mode, probe_sel, ref_mark_sel}, 7'h50);
      u_master.send(0, 16'h1E9C);
      step;
      chk({flying_mode, probe_sel, ref_mark_sel}, 7'h60);
      u_master.send(0, 16'h1EA1);
      chk({fn_read, fn_state}, 5'h14);
      u_master.send(0, 16'hE000);
      chk(fn_state, 4'h1);
      seen = fault_ack;
      step;
      seen |= fault_ack;
      chk({abs_value_request, park_request}, 2'h3);
      step;
      seen |= fault_ack;
      chk(seen, 1'b1);
      $display("encoder word test done");
   endtask
   task automatic test_manual;
      for (int d = 0; d < 4; d++) begin
         u_master.send(2, {13'h1FFF, 2'(d), d[0]});
         step;
         chk({manual_input_absolute, manual_input_direction}, {d[0], (d == 3) ? 2'h0 : 2'(d)});
      end
      u_master.send(1, 16'hFFFF);
      step;
      chk({manual_data_input_active, traversing_block}, 7'h7F);
      u_master.send(1, 16'h7FD5);
      step;
      chk({manual_data_input_active, traversing_block}, 7'h15);
      $display("manual input test done");
   endtask
   task automatic test_options;
      actual_position = 32'h1234_5678;
      commanded_setpoint = 32'h0CAF_E000;
      u_master.send(3, 16'hFFD8);
      step;
      chk({jog_incremental, reference_cam_active, set_reference_point, tracking_mode}, 4'h0);
      chk(position_setpoint, 32'h0CAF_E000);
      u_master.send(3, 16'h0027);
      step;
      chk({jog_incremental, reference_cam_active, set_reference_point, tracking_mode}, 4'hF);
      chk(position_setpoint, 32'h1234_5678);
      actual_position = 32'h0000_4321;
      step;
      chk(position_setpoint, 32'h0000_4321);
      $display("positioning options test done");
   endtask
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      test_encoder;
      test_manual;
      test_options;
      report_and_stop;
   end
   initial begin
      #100000;
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop;
   end
endmodule
